// *** iasb_pkg.sv ***
// constants and state types shared by the interrupt status bank
package iasb_pkg;
    // register addresses on the serial port
    localparam logic [6:0] ADDR_GLOBAL = 7'h60;
    localparam logic [6:0] ADDR_SYSTEM = 7'h61;
    localparam logic [6:0] ADDR_SUPPLY = 7'h62;
    localparam logic [6:0] ADDR_TRX = 7'h63;
    // global summary bit positions
    localparam int SUM_SYSTEM = 0;
    localparam int SUM_SUPPLY = 1;
    localparam int SUM_TRX = 2;
    localparam int SUM_B0_WAKE = 3;
    localparam int SUM_B0_FAIL = 4;
    localparam int SUM_B1_WAKE = 5;
    localparam int SUM_B1_FAIL = 6;
    // system register fields
    localparam int SYS_WATCHDOG = 0;
    localparam int SYS_SERIAL = 1;
    localparam int SYS_OVERTEMP = 2;
    localparam int SYS_POWER_ON = 4;
    localparam int SYS_OV_SHUTDOWN = 5;
    // supply register fields
    localparam int SUP_MAIN_UNDER = 0;
    localparam int SUP_EXT_UNDER = 1;
    localparam int SUP_EXT_OVER = 2;
    localparam int SUP_BAT_UNDER = 3;
    localparam int SUP_BAT_OVER = 4;
    localparam int SUP_REG_CHANGE = 5;
    // transceiver register fields
    localparam int TRX_CAN_WAKE = 0;
    localparam int TRX_CAN_FAIL = 1;
    localparam int TRX_LIN_A_WAKE = 2;
    localparam int TRX_LIN_B_WAKE = 3;
    localparam int TRX_SILENCE = 4;
    localparam int TRX_FRAME_ERR = 5;
    // implemented bits; everything else reads zero
    localparam logic [7:0] SYS_IMPL = 8'h37;
    localparam logic [7:0] SUP_IMPL = 8'h3f;
    localparam logic [7:0] TRX_IMPL = 8'h3f;
    // flags that have no enable and always latch
    localparam logic [7:0] SYS_ALWAYS = 8'h31;
    localparam logic [7:0] TRX_ALWAYS = 8'h20;
    // flags that also pull the fast interrupt line
    localparam logic [7:0] SYS_FAST = 8'h24;
    localparam logic [7:0] SUP_FAST = 8'h39;
    // reset values
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [15:0] SHIFT_RST = 16'h0000;
    // serial frame: 7 address bits, read bit, 8 data bits
    localparam logic [4:0] FRAME_HDR_BITS = 5'h08;
    localparam logic [4:0] FRAME_BITS = 5'h10;
    // clock rate and silence timeout
    localparam int CLK_MHZ = 50;
    localparam int SILENCE_US_DEF = 1000;
    localparam int SILENCE_CNT_W = 32;

    // serial port sequencer, one-hot
    typedef enum logic [2:0] {
        IASB_SPI_IDLE = 3'b001,
        IASB_SPI_SHIFT = 3'b010,
        IASB_SPI_DONE = 3'b100
    } iasb_spi_st_t;

    // all state of the top module
    typedef struct packed {
        iasb_spi_st_t spi;
        logic [4:0] bit_cnt;
        logic [15:0] shift_in;
        logic [7:0] shift_out;
        logic sck_prev;
        logic sdo;
        logic sdo_oe;
        logic [7:0] clr_sys;
        logic [7:0] clr_sup;
        logic [7:0] clr_trx;
        logic reg_state_prev;
        logic reg_state_seen;
        logic [SILENCE_CNT_W-1:0] silence_cnt;
        logic silence_hit;
        logic irq_delayed_n;
        logic irq_fast_n;
    } iasb_top_st_t;

    // state of a flag register
    typedef struct packed {
        logic [7:0] flags;
    } iasb_flag_st_t;

    // state of a three-stage synchroniser
    typedef struct packed {
        logic ff1;
        logic ff2;
        logic ff3;
        logic q;
    } iasb_sync_st_t;
endpackage

// *** iasb_sync3.sv ***
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module iasb_sync3 #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic pin,
    output logic q
);
    import iasb_pkg::*;

    iasb_sync_st_t st; // current state
    iasb_sync_st_t next_st; // next state

    // ff1 feeds only ff2; the filter looks at ff2 and ff3
    always_comb begin
        next_st = st;
        next_st.ff1 = pin;
        next_st.ff2 = st.ff1;
        next_st.ff3 = st.ff2;
        if (st.ff2 == st.ff3) begin // take a change once two stages agree
            next_st.q = st.ff3;
        end
    end

    // register with constant reset
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign q = st.q;
endmodule
`default_nettype wire

// *** iasb_flag.sv ***
// one sticky interrupt status register, cleared by writing one
`timescale 1ns/1ns
`default_nettype none
module iasb_flag #(
    parameter logic [7:0] IMPL = 8'hff
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [7:0] set,
    input wire logic [7:0] clr,
    output logic [7:0] flags
);
    import iasb_pkg::*;

    iasb_flag_st_t st; // current flags
    iasb_flag_st_t next_st; // next flags

    // set beats clear so an event in the clearing cycle survives
    always_comb begin
        next_st = st;
        next_st.flags = ((st.flags & ~clr) | set) & IMPL;
    end

    // register with constant reset
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st.flags <= FLAGS_RST;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign flags = st.flags;
endmodule
`default_nettype wire

// *** iasb_top.sv ***
// interrupt status bank with its serial register port
//
// Functional notes
// - summary shows system, supply, transceiver pending
// - summary bits 3-6 show io banks
// - summary read-only, derived, writes ignored
// - system register flag layout
// - supply register flag layout
// - regulator state toggle sets change flag
// - transceiver register flag layout
// - silence beyond timeout sets silence flag
// - second lin flag only dual variants
// - write one clears, zero keeps
// - interrupt pins high when all clear
// - four flags latch without enable
`timescale 1ns/1ns
`default_nettype none
module iasb_top #(
    parameter bit HAS_BANK0 = 1'b1, // io bank 0 present
    parameter bit HAS_BANK1 = 1'b1, // io bank 1 present
    parameter bit DUAL_LIN = 1'b1, // second lin transceiver present
    parameter int SILENCE_US = iasb_pkg::SILENCE_US_DEF, // bus silence timeout
    parameter int SILENCE_CYCLES = SILENCE_US * iasb_pkg::CLK_MHZ // silence cycles
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    // serial register port pins
    input wire logic spi_sck,
    input wire logic spi_cs_n,
    input wire logic spi_sdi,
    output logic spi_sdo,
    output logic spi_sdo_oe,
    // interrupt enables, one per flag bit
    input wire logic [7:0] sys_irq_enable,
    input wire logic [7:0] sup_irq_enable,
    input wire logic [7:0] trx_irq_enable,
    // one-cycle event pulses from on-chip monitors
    input wire logic [7:0] sys_event,
    input wire logic [7:0] sup_event,
    input wire logic [7:0] trx_event,
    // level of the switched-mode supply status bit
    input wire logic regulator_state_bit,
    // one-cycle pulse on any can bus activity
    input wire logic can_bus_activity,
    // pending levels of the io bank registers
    input wire logic bank0_wake_pending,
    input wire logic bank0_fail_pending,
    input wire logic bank1_wake_pending,
    input wire logic bank1_fail_pending,
    // interrupt pins, active low
    output logic irq_out_delayed_n,
    output logic irq_out_fast_n,
    // register values for observation
    output logic [7:0] global_irq_summary,
    output logic [7:0] system_irq_flags,
    output logic [7:0] supply_irq_flags,
    output logic [7:0] transceiver_irq_flags
);
    import iasb_pkg::*;

    // cut to counter width on purpose
    localparam logic [SILENCE_CNT_W-1:0] SILENCE_LIMIT = SILENCE_CYCLES[SILENCE_CNT_W-1:0];
    // lin b flag exists only with a second transceiver
    localparam logic [7:0] TRX_IMPL_V = DUAL_LIN ? TRX_IMPL
                                                 : (TRX_IMPL & ~(8'h01 << TRX_LIN_B_WAKE));

    iasb_top_st_t st; // current state
    iasb_top_st_t next_st; // next state

    logic sck_s; // filtered serial clock
    logic cs_n_s; // filtered chip select
    logic sdi_s; // filtered data in
    logic [7:0] sys_set; // gated system events
    logic [7:0] sup_set; // gated supply events
    logic [7:0] trx_set; // gated transceiver events
    logic [7:0] sys_q; // system flags
    logic [7:0] sup_q; // supply flags
    logic [7:0] trx_q; // transceiver flags
    logic [7:0] summary; // live global summary
    logic [7:0] rd_val; // value for the addressed register
    logic [6:0] rx_addr; // address from the header

    // pins come from the host's domain, so filter each one
    // cs resets high: no frame from reset
    iasb_sync3 #(.RST_VAL(1'b0)) u_sync_sck (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ce(ce),
        .pin(spi_sck),
        .q(sck_s)
    );
    iasb_sync3 #(.RST_VAL(1'b1)) u_sync_cs (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ce(ce),
        .pin(spi_cs_n),
        .q(cs_n_s)
    );
    iasb_sync3 #(.RST_VAL(1'b0)) u_sync_sdi (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ce(ce),
        .pin(spi_sdi),
        .q(sdi_s)
    );

    // event gating; the always-on flags skip their enables
    always_comb begin
        // reserved bits never pull the pins
        sys_set = sys_event & (sys_irq_enable | SYS_ALWAYS) & SYS_IMPL;
        sup_set = sup_event & sup_irq_enable & SUP_IMPL;
        trx_set = trx_event & (trx_irq_enable | TRX_ALWAYS) & TRX_IMPL_V;
        // regulator toggle in either direction
        sup_set[SUP_REG_CHANGE] = sup_irq_enable[SUP_REG_CHANGE]
            & st.reg_state_seen & (st.reg_state_prev != regulator_state_bit);
        // silence timeout fires as its own event, not a pin pulse
        trx_set[TRX_SILENCE] = trx_irq_enable[TRX_SILENCE] & st.silence_hit;
    end

    // clear strobes last one cycle
    // system flags: wd 0, serial 1, overtemp 2, power-on 4, ov shutdown 5
    iasb_flag #(.IMPL(SYS_IMPL)) u_sys_flags (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ce(ce),
        .set(sys_set),
        .clr(st.clr_sys),
        .flags(sys_q)
    );
    // supply flags: main 0, ext under 1, ext over 2, bat 3/4, regulator 5
    iasb_flag #(.IMPL(SUP_IMPL)) u_sup_flags (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ce(ce),
        .set(sup_set),
        .clr(st.clr_sup),
        .flags(sup_q)
    );
    // transceiver flags: can wake 0, can fail 1, lin 2/3, silence 4, frame 5
    iasb_flag #(.IMPL(TRX_IMPL_V)) u_trx_flags (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ce(ce),
        .set(trx_set),
        .clr(st.clr_trx),
        .flags(trx_q)
    );

    // summary is a pure function of the lower registers, never stored
    always_comb begin
        summary = 8'h00; // bit 7 stays zero
        summary[SUM_SYSTEM] = |sys_q;
        summary[SUM_SUPPLY] = |sup_q;
        summary[SUM_TRX] = |trx_q;
        // absent banks read zero
        summary[SUM_B0_WAKE] = HAS_BANK0 & bank0_wake_pending;
        summary[SUM_B0_FAIL] = HAS_BANK0 & bank0_fail_pending;
        summary[SUM_B1_WAKE] = HAS_BANK1 & bank1_wake_pending;
        summary[SUM_B1_FAIL] = HAS_BANK1 & bank1_fail_pending;
    end

    // read mux; unmapped addresses read zero
    // address sits above the read bit
    always_comb begin
        rx_addr = st.shift_in[7:1];
        case (rx_addr)
            ADDR_GLOBAL: rd_val = summary;
            ADDR_SYSTEM: rd_val = sys_q;
            ADDR_SUPPLY: rd_val = sup_q;
            ADDR_TRX: rd_val = trx_q;
            default: rd_val = 8'h00;
        endcase
    end

    // serial sequencer, silence timer and pin drivers
    always_comb begin
        next_st = st;
        next_st.sck_prev = sck_s;
        // clear strobes last a single cycle
        next_st.clr_sys = 8'h00;
        next_st.clr_sup = 8'h00;
        next_st.clr_trx = 8'h00;
        next_st.sdo_oe = !cs_n_s;
        case (st.spi)
            IASB_SPI_IDLE: begin
                next_st.bit_cnt = 5'h00;
                next_st.shift_in = SHIFT_RST;
                next_st.sdo = 1'b0;
                if (!cs_n_s) begin // frame starts
                    next_st.spi = IASB_SPI_SHIFT;
                end
            end
            IASB_SPI_SHIFT: begin
                if (cs_n_s) begin // frame cut short, drop it
                    next_st.spi = IASB_SPI_IDLE;
                end else if (sck_s && !st.sck_prev) begin
                    // sample on rising edge, msb first
                    next_st.shift_in = {st.shift_in[14:0], sdi_s};
                    next_st.bit_cnt = st.bit_cnt + 5'h01;
                    if (st.bit_cnt == FRAME_HDR_BITS - 5'h01) begin
                        // header complete; address is in bits 7:1 after this shift
                        next_st.shift_out = 8'h00;
                    end
                    if (st.bit_cnt == FRAME_BITS - 5'h01) begin
                        next_st.spi = IASB_SPI_DONE;
                        // write frame: read bit low; only flag registers clear
                        if (!st.shift_in[7]) begin
                            case (st.shift_in[14:8])
                                ADDR_SYSTEM: next_st.clr_sys = {st.shift_in[6:0], sdi_s};
                                ADDR_SUPPLY: next_st.clr_sup = {st.shift_in[6:0], sdi_s};
                                ADDR_TRX: next_st.clr_trx = {st.shift_in[6:0], sdi_s};
                                default: next_st.clr_sys = 8'h00; // summary write ignored
                            endcase
                        end
                    end
                end else if (!sck_s && st.sck_prev) begin
                    // shift data out on falling edge
                    if (st.bit_cnt == FRAME_HDR_BITS) begin
                        // msb first, rest in shift_out
                        next_st.sdo = rd_val[7];
                        next_st.shift_out = {rd_val[6:0], 1'b0};
                    end else if (st.bit_cnt > FRAME_HDR_BITS) begin
                        next_st.sdo = st.shift_out[7];
                        next_st.shift_out = {st.shift_out[6:0], 1'b0};
                    end
                end
            end
            IASB_SPI_DONE: begin
                // longer frames are tolerated; extra bits are ignored
                if (cs_n_s) begin
                    next_st.spi = IASB_SPI_IDLE;
                end
            end
            default: begin
                next_st.spi = IASB_SPI_IDLE;
            end
        endcase

        // regulator bit history; first sample only arms the detector
        // arm bit hides the reset edge
        next_st.reg_state_prev = regulator_state_bit;
        next_st.reg_state_seen = 1'b1;

        // silence timer; pulses once when the limit is passed
        // parks past the limit: one flag per gap
        next_st.silence_hit = 1'b0;
        if (can_bus_activity) begin
            next_st.silence_cnt = '0;
        end else if (st.silence_cnt <= SILENCE_LIMIT) begin
            next_st.silence_cnt = st.silence_cnt + 1'b1;
            next_st.silence_hit = (st.silence_cnt == SILENCE_LIMIT);
        end

        // delayed pin falls while anything is pending, rises when all is clear
        // new events pull the pin at once
        next_st.irq_delayed_n = !(|sys_set || |sup_set || |trx_set
                                  || |summary);
        // fast pin: urgent sources only
        next_st.irq_fast_n = !(|(sys_set & SYS_FAST) || |(sup_set & SUP_FAST)
                               || |(sys_q & SYS_FAST) || |(sup_q & SUP_FAST));
    end

    // single state register; all control state resets to a constant
    // ce low freezes every flop
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st.spi <= IASB_SPI_IDLE;
            st.bit_cnt <= 5'h00;
            st.shift_in <= SHIFT_RST;
            st.shift_out <= 8'h00;
            st.sck_prev <= 1'b0;
            st.sdo <= 1'b0;
            st.sdo_oe <= 1'b0;
            st.clr_sys <= 8'h00;
            st.clr_sup <= 8'h00;
            st.clr_trx <= 8'h00;
            st.reg_state_prev <= 1'b0;
            st.reg_state_seen <= 1'b0;
            st.silence_cnt <= '0;
            st.silence_hit <= 1'b0;
            st.irq_delayed_n <= 1'b1;
            st.irq_fast_n <= 1'b1;
        end else if (ce) begin
            st <= next_st;
        end
    end

    // registered outputs; flag outputs come from the flag flops
    // summary stays a live decode
    assign spi_sdo = st.sdo;
    assign spi_sdo_oe = st.sdo_oe;
    assign irq_out_delayed_n = st.irq_delayed_n;
    assign irq_out_fast_n = st.irq_fast_n;
    assign system_irq_flags = sys_q;
    assign supply_irq_flags = sup_q;
    assign transceiver_irq_flags = trx_q;
    assign global_irq_summary = summary; // decoded from flag flops and bank inputs
endmodule
`default_nettype wire

// *** iasb_chk_assertions.sv ***
// concurrent checks on the ports of the interrupt status bank
`timescale 1ns/1ns
`default_nettype none
module iasb_chk
    import iasb_pkg::*;
#(
    parameter bit HAS_BANK0 = 1'b1,
    parameter bit HAS_BANK1 = 1'b1,
    parameter bit DUAL_LIN = 1'b1,
    parameter int SILENCE_CYCLES = 20
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic spi_cs_n,
    input wire logic [7:0] sup_irq_enable,
    input wire logic [7:0] trx_irq_enable,
    input wire logic [7:0] sys_event,
    input wire logic regulator_state_bit,
    input wire logic can_bus_activity,
    input wire logic bank0_wake_pending,
    input wire logic bank0_fail_pending,
    input wire logic bank1_wake_pending,
    input wire logic bank1_fail_pending,
    input wire logic irq_out_delayed_n,
    input wire logic [7:0] global_irq_summary,
    input wire logic [7:0] system_irq_flags,
    input wire logic [7:0] supply_irq_flags,
    input wire logic [7:0] transceiver_irq_flags
);
    logic [7:0] quiet; // cycles without bus activity, saturating
    logic [3:0] cs_hi; // cycles with chip select high, saturating
    logic [23:0] all_f; // every flag bit side by side
    logic bank_any; // any io bank pending
    assign all_f = {system_irq_flags, supply_irq_flags, transceiver_irq_flags};
    assign bank_any = bank0_wake_pending | bank0_fail_pending | bank1_wake_pending
        | bank1_fail_pending;
    // saturating: a long idle never wraps
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            quiet <= 8'h00;
            cs_hi <= 4'h0;
        end else begin
            quiet <= can_bus_activity ? 8'h00 : quiet + {7'h00, quiet != 8'hff};
            cs_hi <= !spi_cs_n ? 4'h0 : cs_hi + {3'h0, cs_hi != 4'hf};
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    a_summary_decode: assert property (
        global_irq_summary == {1'b0, HAS_BANK1 && bank1_fail_pending,
        HAS_BANK1 && bank1_wake_pending, HAS_BANK0 && bank0_fail_pending,
        HAS_BANK0 && bank0_wake_pending, |transceiver_irq_flags,
        |supply_irq_flags, |system_irq_flags})
        else $error("summary differs from lower registers");
    a_always_latch: assert property (
        ce && sys_event[SYS_WATCHDOG] |=> system_irq_flags[SYS_WATCHDOG])
        else $error("watchdog flag did not latch");
    a_flags_sticky: assert property (
        cs_hi == 4'hf |-> (~all_f & $past(all_f)) == 24'h0)
        else $error("flag dropped without a serial write");
    a_irq_release: assert property (
        (all_f == 24'h0 && !bank_any) [*2] |-> irq_out_delayed_n)
        else $error("interrupt pin low with nothing pending");
    a_reserved_zero: assert property (
        (system_irq_flags & ~SYS_IMPL) == 8'h00 && (supply_irq_flags & ~SUP_IMPL) == 8'h00
        && (transceiver_irq_flags & ~TRX_IMPL) == 8'h00)
        else $error("reserved flag bit set");
    a_single_lin: assert property (
        !DUAL_LIN |-> !transceiver_irq_flags[TRX_LIN_B_WAKE])
        else $error("second lin flag in single lin variant");
    a_regulator_toggle: assert property (
        $changed(regulator_state_bit) && sup_irq_enable[SUP_REG_CHANGE]
        |-> ##[1:8] supply_irq_flags[SUP_REG_CHANGE])
        else $error("regulator change not flagged");
    a_bus_silence: assert property (
        quiet == SILENCE_CYCLES + 8 && trx_irq_enable[TRX_SILENCE]
        |-> transceiver_irq_flags[TRX_SILENCE])
        else $error("bus silence not flagged");
endmodule
bind iasb_top iasb_chk #(.HAS_BANK0(HAS_BANK0), .HAS_BANK1(HAS_BANK1), .DUAL_LIN(DUAL_LIN),
    .SILENCE_CYCLES(SILENCE_CYCLES)) u_chk (.clk_sys, .rst_n, .ce, .spi_cs_n,
    .sup_irq_enable, .trx_irq_enable, .sys_event, .regulator_state_bit, .can_bus_activity,
    .bank0_wake_pending, .bank0_fail_pending, .bank1_wake_pending, .bank1_fail_pending,
    .irq_out_delayed_n, .global_irq_summary, .system_irq_flags, .supply_irq_flags,
    .transceiver_irq_flags);
`default_nettype wire

// *** iasb_host.sv ***
// host model driving the serial register port
`timescale 1ns/1ns
`default_nettype none
module iasb_host (
    input wire logic clk_sys,
    input wire logic spi_sdo,
    output logic spi_sck,
    output logic spi_cs_n,
    output logic spi_sdi
);
    // idle: deselected, clock low
    initial begin
        spi_sck = 1'b0;
        spi_cs_n = 1'b1;
        spi_sdi = 1'b0;
    end
    // one frame, msb first, mode 0; slow sck for the filters
    task automatic xfer(input logic [15:0] word, output logic [7:0] rdata);
        int i;
        rdata = 8'h00;
        @(negedge clk_sys);
        spi_cs_n = 1'b0;
        for (i = 15; i >= 0; i--) begin
            spi_sdi = word[i];
            repeat (8) @(negedge clk_sys);
            if (i < 8) rdata[i] = spi_sdo;
            spi_sck = 1'b1;
            repeat (8) @(negedge clk_sys);
            spi_sck = 1'b0;
        end
        repeat (8) @(negedge clk_sys);
        spi_cs_n = 1'b1;
        spi_sdi = ~spi_sdi; // released line must not show a stale bit
        repeat (8) @(negedge clk_sys);
    endtask
endmodule
`default_nettype wire

// *** iasb_top_bench.sv ***
// self-checking bench of the interrupt status bank
`timescale 1ns/1ns
`default_nettype none
module iasb_top_bench;
    import iasb_pkg::*;
    logic clk_sys, rst_n, ce, spi_sck, spi_cs_n, spi_sdi, spi_sdo, spi_sdo_oe;
    logic [7:0] sys_irq_enable, sup_irq_enable, trx_irq_enable;
    logic [7:0] sys_event, sup_event, trx_event;
    logic regulator_state_bit, can_bus_activity, irq_out_delayed_n, irq_out_fast_n;
    logic bank0_wake_pending, bank0_fail_pending, bank1_wake_pending, bank1_fail_pending;
    logic [7:0] global_irq_summary, system_irq_flags, supply_irq_flags, transceiver_irq_flags;
    logic [7:0] sum_b, trx_b; // single lin variant without bank 1
    int m_sys, m_sup, m_trx; // model of the three flag registers
    int errors = 0;
    int samples_checked = 0;
    iasb_top #(.SILENCE_CYCLES(20)) uut (.*);
    iasb_top #(.HAS_BANK1(1'b0), .DUAL_LIN(1'b0), .SILENCE_CYCLES(20)) uut_b (.*,
        .spi_sdo(), .spi_sdo_oe(), .irq_out_delayed_n(), .irq_out_fast_n(),
        .global_irq_summary(sum_b), .system_irq_flags(), .supply_irq_flags(),
        .transceiver_irq_flags(trx_b));
    iasb_host host (.clk_sys, .spi_sdo, .spi_sck, .spi_cs_n, .spi_sdi);
    // free-running system clock
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    // expected summary from the model and the bank levels
    function automatic int sum_m();
        return {bank1_fail_pending, bank1_wake_pending, bank0_fail_pending,
            bank0_wake_pending, m_trx != 0, m_sup != 0, m_sys != 0};
    endfunction
    // expected value by register offset
    function automatic int reg_m(input int a);
        case (a)
            0: return sum_m();
            1: return m_sys;
            2: return m_sup;
            3: return m_trx;
            default: return 0;
        endcase
    endfunction
    task automatic chk(input logic [7:0] got, input int exp, input string what);
        samples_checked++;
        if (got !== exp[7:0]) begin
            errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp[7:0]);
        end
    endtask
    task automatic cmp_all();
        chk(system_irq_flags, m_sys, "system");
        chk(supply_irq_flags, m_sup, "supply");
        chk(transceiver_irq_flags, m_trx, "transceiver");
        chk(global_irq_summary, sum_m(), "summary");
        chk(trx_b, m_trx & 8'hf7, "single lin");
        chk(sum_b, sum_m() & 8'h1f, "reduced summary");
        chk({7'h00, irq_out_delayed_n}, int'(sum_m() == 0), "irq pin");
        chk({6'h00, spi_sdo_oe, irq_out_fast_n}, int'((m_sys & SYS_FAST | m_sup & SUP_FAST) == 0),
            "fast pin");
    endtask
    // one-cycle event pulses; disabled and reserved bits must not latch
    task automatic pulse(input logic [7:0] se, input logic [7:0] ue, input logic [7:0] te);
        sys_event = se;
        sup_event = ue;
        trx_event = te;
        m_sys |= se & (sys_irq_enable | SYS_ALWAYS) & SYS_IMPL;
        m_sup |= ue & sup_irq_enable & SUP_IMPL & 8'hdf;
        m_trx |= te & (trx_irq_enable | TRX_ALWAYS) & TRX_IMPL & 8'hef;
        @(negedge clk_sys);
        sys_event = 8'h00;
        sup_event = 8'h00;
        trx_event = 8'h00;
        @(negedge clk_sys);
        cmp_all();
    endtask
    task automatic rd_chk(input logic [6:0] a, input int exp);
        logic [7:0] q;
        host.xfer({a, 1'b1, 8'h00}, q);
        chk(q, exp, "serial read");
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] q;
        host.xfer({a, 1'b0, d}, q);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // watchdog: tests take ~4000 cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        summarize();
    end
    // main sequence
    initial begin
        int i;
        logic [7:0] d;
        {rst_n, sys_irq_enable, sup_irq_enable, trx_irq_enable} = '0;
        {sys_event, sup_event, trx_event, regulator_state_bit} = '0;
        {bank0_wake_pending, bank0_fail_pending, bank1_wake_pending, bank1_fail_pending} = '0;
        {m_sys, m_sup, m_trx} = '0;
        ce = 1'b1;
        can_bus_activity = 1'b1; // constant activity keeps the silence timer quiet
        repeat (3) @(negedge clk_sys);
        rst_n = 1'b1;
        void'($urandom(32'h76cef43e));
        cmp_all();
        // random enables, banks and events; flags accumulate
        for (i = 0; i < 40; i++) begin
            sys_irq_enable = 8'($urandom);
            sup_irq_enable = 8'($urandom);
            trx_irq_enable = 8'($urandom) & 8'hef;
            {bank1_fail_pending, bank1_wake_pending, bank0_fail_pending,
                bank0_wake_pending} = 4'($urandom);
            pulse(8'($urandom), 8'($urandom), 8'($urandom));
        end
        for (i = 0; i < 4; i++) rd_chk(7'(ADDR_GLOBAL + i), reg_m(i));
        rd_chk(7'h70, 0);
        wr(ADDR_GLOBAL, 8'hff);
        cmp_all();
        wr(ADDR_SYSTEM, 8'h00);
        cmp_all();
        d = 8'($urandom);
        wr(ADDR_SUPPLY, d);
        m_sup &= ~int'(d);
        cmp_all();
        {bank0_wake_pending, bank0_fail_pending, bank1_wake_pending, bank1_fail_pending} = '0;
        for (i = 1; i < 4; i++) wr(7'(ADDR_GLOBAL + i), 8'hff);
        {m_sys, m_sup, m_trx} = '0;
        cmp_all();
        // regulator toggles in both directions
        sup_irq_enable = 8'h20;
        for (i = 0; i < 2; i++) begin
            regulator_state_bit = ~regulator_state_bit;
            repeat (8) @(negedge clk_sys);
            m_sup |= 8'h20;
            cmp_all();
            wr(ADDR_SUPPLY, 8'h20);
            m_sup = 0;
        end
        // short gap must not flag, a long one must
        trx_irq_enable = 8'h10;
        can_bus_activity = 1'b0;
        repeat (10) @(negedge clk_sys);
        can_bus_activity = 1'b1;
        repeat (2) @(negedge clk_sys);
        cmp_all();
        can_bus_activity = 1'b0;
        repeat (40) @(negedge clk_sys);
        m_trx |= 8'h10;
        cmp_all();
        can_bus_activity = 1'b1;
        summarize();
    end
endmodule
`default_nettype wire
